// File: verilog/iqd_consts.svh
/*
  Constants of the I/Q demodulator datapath: register indices, field positions,
  frame lengths, shift figures and saturation bounds.
  Assumes inclusion by bare name from the package and the datapath file.
*/
`ifndef IQD_CONSTS_SVH
`define IQD_CONSTS_SVH

// Serial frame: 8 address bits, then a data field
`define IQD_ADDR_LAST 7'h07
`define IQD_SUB_LSB 6
`define IQD_LEN_REG 7'h10
`define IQD_LEN_COEFF 7'h70
`define IQD_LEN_PROF 7'h40

// Register indices (low six address bits)
`define IQD_REG_COEFF_PTR 6'h06
`define IQD_REG_COEFF_PORT 6'h07
`define IQD_REG_PROF_PTR 6'h08
`define IQD_REG_PROF_PORT 6'h09
`define IQD_REG_BYPASS 6'h0A
`define IQD_REG_PROF_SEL 6'h0E
`define IQD_REG_OFS_A 6'h14
`define IQD_REG_OFS_D 6'h17
`define IQD_REG_TEST 6'h1D
`define IQD_REG_SINE 6'h1E
`define IQD_REG_MDEC 6'h1F
`define IQD_REG_MFREQ_EN 6'h20
`define IQD_REG_MFREQ 6'h21

// Bypass and option bits
`define IQD_BYP_OFFSET 0
`define IQD_BYP_MIXER 2
`define IQD_BYP_DEC 3
`define IQD_PHASE_RST 10
`define IQD_SHIFT_SCALE 13

// Test and shift control fields
`define IQD_WAVE_EN 2
`define IQD_IMP_EN 3
`define IQD_FORCE_EN 7
`define IQD_FORCE_HI 6
`define IQD_FORCE_LO 4

// Test wave fields
`define IQD_WOFS_HI 15
`define IQD_WOFS_LO 9
`define IQD_WAMP_HI 8
`define IQD_WAMP_LO 5
`define IQD_WSTEP_HI 4
`define IQD_WSTEP_LO 0

// Manual decimation fields
`define IQD_MDEC_EN 6
`define IQD_MDEC_HI 5
`define IQD_MDEC_LO 0
`define IQD_CS_EN 15
`define IQD_CS_HI 14
`define IQD_CS_LO 7
`define IQD_MFREQ_BIT 0

// Profile word fields
`define IQD_PR_P_HI 35
`define IQD_PR_P_LO 28
`define IQD_PR_M_HI 27
`define IQD_PR_M_LO 22
`define IQD_PR_F_HI 21
`define IQD_PR_F_LO 6
`define IQD_PR_G_HI 4
`define IQD_PR_G_LO 2
`define IQD_PR_SEL_HI 15
`define IQD_PR_SEL_LO 11

// Arithmetic figures
`define IQD_SHIFT_BASE 6'h14
`define IQD_SHIFT_DROP 6'h02
`define IQD_IMPULSE 16'h4000
`define IQD_WAVE_FRAC 13
`define IQD_NCO_HI 15
`define IQD_NCO_LO 10
`define IQD_QUARTER 6'h10
`define IQD_S14_MAX 32'sh00001FFF
`define IQD_S14_MIN -32'sh00002000
`define IQD_S16_MAX 36'sh00007FFF
`define IQD_S16_MIN -36'sh000008000
`define IQD_INFLIGHT 4

`endif

// File: verilog/iqd_pkg.sv
/*
  Types of the I/Q demodulator datapath: the state record of the top module.
  Assumes the constants header is on the include path.
*/
package iqd_pkg;
   `include "iqd_consts.svh"

   typedef struct packed {
      logic [1:0] sen_s;
      logic [1:0] sclk_s;
      logic [1:0] sdat_s;
      logic [1:0] dsel_s;
      logic [1:0] fire_s;
      logic sclk_prev;
      logic fire_prev;
      logic [6:0] bit_cnt;
      logic addr_done;
      logic [7:0] addr;
      logic [111:0] shift;
      logic [15:0] coeff_ptr;
      logic [15:0] prof_ptr;
      logic [15:0] bypass;
      logic [15:0] prof_sel;
      logic [3:0][15:0] ofs;
      logic [15:0] test;
      logic [15:0] sine;
      logic [15:0] mdec;
      logic [15:0] mfreq_en;
      logic [15:0] mfreq;
      logic [5:0] wave_ph;
      logic s1_v;
      logic [13:0] s1;
      logic [15:0] nco;
      logic s2_v;
      logic [13:0] s2_i;
      logic [13:0] s2_q;
      logic [10:0] imp_cnt;
      logic [6:0] pos;
      logic [15:0][35:0] acc_i;
      logic [15:0][35:0] acc_q;
      logic adc_ready;
   } iqd_state_t;
endpackage

// File: verilog/iqd_datapath.sv
/*
  I/Q demodulator datapath for one channel: serial register port, profile and
  coefficient memories, test sources, offset removal, mixer, polyphase decimator
  and an output FIFO.
  Assumes clk is the 40 MHz sample clock, the serial clock is at most clk/6,
  and the serializer drains the FIFO through out_valid/out_ready.
*/
`timescale 1ns/1ps
`include "iqd_consts.svh"

module iqd_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+2)-1:0] level
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+2);
   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [CW-1:0] cnt;
      logic ov;
      logic [WIDTH-1:0] od;
   } iqd_fifo_state_t;

   iqd_fifo_state_t st;
   iqd_fifo_state_t next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic load;

   assign in_ready = st.cnt < CW'(DEPTH);
   assign push = ce && in_valid && in_ready;
   assign load = ce && (!st.ov || out_ready) && (st.cnt != '0);
   assign out_valid = st.ov;
   assign out_data = st.od;
   assign level = st.cnt + CW'(st.ov);

   // Output word is registered so the serializer sees flop-driven data
   always_comb
   begin
      next_st = st;
      if (ce && out_ready && st.ov)
      begin
         next_st.ov = 1'b0;
      end
      if (load)
      begin
         next_st.od = mem[st.rd];
         next_st.ov = 1'b1;
         next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
      end
      if (push)
      begin
         next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
      end
      next_st.cnt = st.cnt + CW'(push) - CW'(load);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Storage carries no reset, it is only read behind the count
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[st.wr] <= in_data;
      end
   end
endmodule // iqd_fifo

module iqd_datapath #(
   parameter int SUBCHIP = 0,
   parameter int CH_PAIR = 0,
   parameter int FIFO_DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic serial_enable_n,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic digital_subchip_select,
   input wire logic transmit_fire_pulse,
   input wire logic [13:0] adc_data,
   input wire logic adc_valid,
   output logic adc_ready,
   output logic out_valid,
   input wire logic out_ready,
   output logic [15:0] out_i,
   output logic [15:0] out_q
);
   localparam int LW = $clog2(FIFO_DEPTH+2);
   // Quarter-wave sine, 8192 full scale, points k*pi/32 for k = 0..16
   localparam logic [16:0][13:0] QSINE = {
      14'h2000, 14'h1FD9, 14'h1F63, 14'h1E9F, 14'h1D90, 14'h1C39, 14'h1A9B, 14'h18BD,
      14'h16A1, 14'h144D, 14'h11C7, 14'h0F16, 14'h0C3F, 14'h094A, 14'h063E, 14'h0323, 14'h0000};

   iqd_pkg::iqd_state_t st;
   iqd_pkg::iqd_state_t next_st;
   logic [111:0] coeff_ram [256];
   logic [63:0] prof_ram [32];

   logic coef_we;
   logic [7:0] coef_wa;
   logic [111:0] coef_wd;
   logic prof_we;
   logic [4:0] prof_wa;
   logic [63:0] prof_wd;
   logic push;
   logic [31:0] push_data;
   logic fifo_in_ready;
   logic [LW-1:0] fifo_level;

   logic [63:0] prof;
   logic [15:0] freq;
   logic [6:0] m_eff;
   logic [7:0] cstart;
   logic [2:0] gain;
   logic [5:0] n_shift;
   logic [111:0] blk_a;
   logic [111:0] blk_b;
   logic [15:0] fi;
   logic [15:0] fq;
   logic [15:0][35:0] prod_i;
   logic [15:0][35:0] prod_q;

   function automatic logic signed [14:0] wave_lut(input logic [5:0] idx);
      logic [4:0] k;
      logic [13:0] mag;
      k = idx[4] ? 5'h10 - {1'b0, idx[3:0]} : {1'b0, idx[3:0]};
      mag = QSINE[k];
      wave_lut = idx[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
   endfunction

   function automatic logic [13:0] sat14(input logic signed [31:0] v);
      if (v > `IQD_S14_MAX)
         sat14 = 14'h1FFF;
      else if (v < `IQD_S14_MIN)
         sat14 = 14'h2000;
      else
         sat14 = v[13:0];
   endfunction

   function automatic logic [15:0] sat16(input logic signed [35:0] v);
      if (v > `IQD_S16_MAX)
         sat16 = 16'h7FFF;
      else if (v < `IQD_S16_MIN)
         sat16 = 16'h8000;
      else
         sat16 = v[15:0];
   endfunction

   // Active profile and manual overrides
   assign prof = prof_ram[st.prof_sel[`IQD_PR_SEL_HI:`IQD_PR_SEL_LO]];
   assign freq = st.mfreq_en[`IQD_MFREQ_BIT] ? st.mfreq : prof[`IQD_PR_F_HI:`IQD_PR_F_LO];
   // A factor field of zero is taken as 64, the top of the range
   assign m_eff = {(st.mdec[`IQD_MDEC_EN] ? st.mdec[`IQD_MDEC_HI:`IQD_MDEC_LO] : prof[`IQD_PR_M_HI:`IQD_PR_M_LO])
      == 6'h00, st.mdec[`IQD_MDEC_EN] ? st.mdec[`IQD_MDEC_HI:`IQD_MDEC_LO] : prof[`IQD_PR_M_HI:`IQD_PR_M_LO]};
   assign cstart = st.mdec[`IQD_CS_EN] ? st.mdec[`IQD_CS_HI:`IQD_CS_LO] : prof[`IQD_PR_P_HI:`IQD_PR_P_LO];
   assign gain = st.test[`IQD_FORCE_EN] ? st.test[`IQD_FORCE_HI:`IQD_FORCE_LO] : prof[`IQD_PR_G_HI:`IQD_PR_G_LO];
   assign n_shift = (st.bypass[`IQD_SHIFT_SCALE] ? `IQD_SHIFT_BASE - `IQD_SHIFT_DROP : `IQD_SHIFT_BASE)
      - {3'h0, gain};

   // Two polyphase blocks per sample: forward half and mirrored half
   assign blk_a = coeff_ram[cstart + {1'b0, st.pos}];
   assign blk_b = coeff_ram[cstart + 8'(m_eff - 7'h01 - st.pos)];

   // Filter input: impulse source replaces the mixer output
   assign fi = st.test[`IQD_IMP_EN] ? ((st.imp_cnt == '0) ? `IQD_IMPULSE : 16'h0000)
      : {{2{st.s2_i[13]}}, st.s2_i};
   assign fq = st.test[`IQD_IMP_EN] ? ((st.imp_cnt == '0) ? `IQD_IMPULSE : 16'h0000)
      : {{2{st.s2_q[13]}}, st.s2_q};

   // Tap k < 8 uses coefficient k of block a, tap k >= 8 coefficient 15-k of block b
   for (genvar k = 0; k < 16; k++)
   begin : g_tap
      logic signed [13:0] cf;
      if (k < 8)
      begin : g_fwd
         assign cf = blk_a[14*k +: 14];
      end
      else
      begin : g_mir
         assign cf = blk_b[14*(15-k) +: 14];
      end
      assign prod_i[k] = 36'($signed(fi) * cf);
      assign prod_q[k] = 36'($signed(fq) * cf);
   end

   always_comb
   begin
      logic sclk_rise;
      logic fire_rise;
      logic [111:0] shift_new;
      logic [5:0] ridx;
      logic [6:0] flen;
      logic signed [31:0] src;
      logic signed [31:0] tmp;
      logic signed [31:0] mix;
      logic [13:0] s1_new;
      logic [35:0] sum;
      logic [35:0] y_i;
      logic [35:0] y_q;
      sclk_rise = 1'b0;
      fire_rise = 1'b0;
      shift_new = '0;
      ridx = '0;
      flen = '0;
      src = '0;
      tmp = '0;
      mix = '0;
      s1_new = '0;
      sum = '0;
      y_i = '0;
      y_q = '0;
      next_st = st;
      coef_we = 1'b0;
      coef_wa = st.coeff_ptr[7:0];
      coef_wd = '0;
      prof_we = 1'b0;
      prof_wa = st.prof_ptr[4:0];
      prof_wd = '0;
      push = 1'b0;
      push_data = '0;

      // Pin synchronisers; only the second stage is read
      next_st.sen_s = {st.sen_s[0], serial_enable_n};
      next_st.sclk_s = {st.sclk_s[0], serial_clk};
      next_st.sdat_s = {st.sdat_s[0], serial_data};
      next_st.dsel_s = {st.dsel_s[0], digital_subchip_select};
      next_st.fire_s = {st.fire_s[0], transmit_fire_pulse};
      next_st.sclk_prev = st.sclk_s[1];
      next_st.fire_prev = st.fire_s[1];
      sclk_rise = st.sclk_s[1] && !st.sclk_prev;
      fire_rise = st.fire_s[1] && !st.fire_prev;

      // Serial write frame: address, then data MSB first; the data field repeats
      // under one address so consecutive blocks stream without a new frame
      ridx = st.addr[5:0];
      flen = (ridx == `IQD_REG_COEFF_PORT) ? `IQD_LEN_COEFF :
         (ridx == `IQD_REG_PROF_PORT) ? `IQD_LEN_PROF : `IQD_LEN_REG;
      shift_new = {st.shift[110:0], st.sdat_s[1]};
      if (st.sen_s[1])
      begin
         next_st.bit_cnt = '0;
         next_st.addr_done = 1'b0;
      end
      else if (sclk_rise)
      begin
         next_st.shift = shift_new;
         next_st.bit_cnt = st.bit_cnt + 7'h01;
         if (!st.addr_done)
         begin
            if (st.bit_cnt == `IQD_ADDR_LAST)
            begin
               next_st.addr = shift_new[7:0];
               next_st.addr_done = 1'b1;
               next_st.bit_cnt = '0;
            end
         end
         else if (st.bit_cnt == flen - 7'h01)
         begin
            next_st.bit_cnt = '0;
            // Demodulator writes only with the subchip select low and our id bit set
            if (!st.dsel_s[1] && st.addr[`IQD_SUB_LSB + SUBCHIP])
            begin
               unique case (ridx)
                  `IQD_REG_COEFF_PTR: next_st.coeff_ptr = shift_new[15:0];
                  `IQD_REG_COEFF_PORT:
                  begin
                     coef_we = 1'b1;
                     coef_wd = shift_new;
                     next_st.coeff_ptr[7:0] = st.coeff_ptr[7:0] + 8'h01;
                  end
                  `IQD_REG_PROF_PTR: next_st.prof_ptr = shift_new[15:0];
                  `IQD_REG_PROF_PORT:
                  begin
                     prof_we = 1'b1;
                     prof_wd = shift_new[63:0];
                     next_st.prof_ptr[4:0] = st.prof_ptr[4:0] + 5'h01;
                  end
                  `IQD_REG_BYPASS: next_st.bypass = shift_new[15:0];
                  `IQD_REG_PROF_SEL: next_st.prof_sel = shift_new[15:0];
                  `IQD_REG_TEST: next_st.test = shift_new[15:0];
                  `IQD_REG_SINE: next_st.sine = shift_new[15:0];
                  `IQD_REG_MDEC: next_st.mdec = shift_new[15:0];
                  `IQD_REG_MFREQ_EN: next_st.mfreq_en = shift_new[15:0];
                  `IQD_REG_MFREQ: next_st.mfreq = shift_new[15:0];
                  default:
                  begin
                     if (ridx >= `IQD_REG_OFS_A && ridx <= `IQD_REG_OFS_D)
                     begin
                        next_st.ofs[2'(ridx - `IQD_REG_OFS_A)] = shift_new[15:0];
                     end
                  end
               endcase
            end
         end
      end

      // Stage 1: test wave source, then offset removal
      next_st.s1_v = adc_valid && st.adc_ready;
      if (adc_valid && st.adc_ready)
      begin
         src = 32'($signed(adc_data));
         if (st.test[`IQD_WAVE_EN])
         begin
            tmp = 32'(wave_lut(st.wave_ph));
            tmp = (tmp <<< st.sine[`IQD_WAMP_HI:`IQD_WAMP_LO]) >>> `IQD_WAVE_FRAC;
            tmp = tmp + 32'($signed(st.sine[`IQD_WOFS_HI:`IQD_WOFS_LO]));
            src = 32'($signed(sat14(tmp)));
            next_st.wave_ph = st.wave_ph + {1'b0, st.sine[`IQD_WSTEP_HI:`IQD_WSTEP_LO]};
         end
         if (st.bypass[`IQD_BYP_OFFSET])
            s1_new = src[13:0];
         else
            s1_new = sat14(src - 32'($signed(st.ofs[CH_PAIR][13:0])));
         next_st.s1 = s1_new;
      end

      // Stage 2: mixer against the oscillator; I = x cos, Q = -x sin
      next_st.s2_v = st.s1_v;
      if (st.s1_v)
      begin
         next_st.nco = st.nco + freq;
         if (st.bypass[`IQD_BYP_MIXER])
         begin
            next_st.s2_i = st.s1;
            next_st.s2_q = '0;
         end
         else
         begin
            mix = (32'($signed(st.s1)) * 32'(wave_lut(st.nco[`IQD_NCO_HI:`IQD_NCO_LO] + `IQD_QUARTER)))
               >>> `IQD_WAVE_FRAC;
            next_st.s2_i = sat14(mix);
            mix = (32'($signed(st.s1)) * 32'(wave_lut(st.nco[`IQD_NCO_HI:`IQD_NCO_LO]))) >>> `IQD_WAVE_FRAC;
            next_st.s2_q = sat14(-mix);
         end
      end
      // Phase restart wins over the advance in the same cycle
      if (fire_rise && st.bypass[`IQD_PHASE_RST])
      begin
         next_st.nco = '0;
      end

      // Stage 3: transposed polyphase decimator; acc[k] holds output a+k
      if (st.s2_v)
      begin
         next_st.imp_cnt = (st.imp_cnt >= {m_eff, 4'h0}) ? '0 : st.imp_cnt + 11'h001;
         if (st.bypass[`IQD_BYP_DEC])
         begin
            push = 1'b1;
            push_data = {fi, fq};
         end
         else
         begin
            y_i = st.acc_i[0] + prod_i[0];
            y_q = st.acc_q[0] + prod_q[0];
            if ({1'b0, st.pos} >= {1'b0, m_eff} - 8'h01)
            begin
               next_st.pos = '0;
               for (int k = 0; k < 15; k++)
               begin
                  sum = st.acc_i[k+1] + prod_i[k+1];
                  next_st.acc_i[k] = sum;
                  sum = st.acc_q[k+1] + prod_q[k+1];
                  next_st.acc_q[k] = sum;
               end
               next_st.acc_i[15] = '0;
               next_st.acc_q[15] = '0;
               push = 1'b1;
               push_data = {sat16($signed(y_i) >>> n_shift), sat16($signed(y_q) >>> n_shift)};
            end
            else
            begin
               next_st.pos = st.pos + 7'h01;
               for (int k = 0; k < 16; k++)
               begin
                  sum = st.acc_i[k] + prod_i[k];
                  next_st.acc_i[k] = sum;
                  sum = st.acc_q[k] + prod_q[k];
                  next_st.acc_q[k] = sum;
               end
            end
         end
      end

      // Input is held off while the FIFO cannot absorb the samples in flight
      next_st.adc_ready = ((32'(fifo_level) + `IQD_INFLIGHT) <= FIFO_DEPTH) && fifo_in_ready;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st <= '0;
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   // Memories are never cleared; contents are undefined until loaded
   always_ff @(posedge clk)
   begin
      if (ce && coef_we)
      begin
         coeff_ram[coef_wa] <= coef_wd;
      end
      if (ce && prof_we)
      begin
         prof_ram[prof_wa] <= prof_wd;
      end
   end

   iqd_fifo #(
      .WIDTH(32),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data({out_i, out_q}),
      .level(fifo_level)
   );

   // Port is the flop itself, so stage 1 and the source agree on every take
   assign adc_ready = st.adc_ready;
endmodule // iqd_datapath

// File: verification/iqd_datapath_chk.sv
/*
  Port checker for the demodulator datapath.
  Assumes a bind to iqd_datapath, with clk as the only clock.
*/
`timescale 1ns/1ps
module iqd_datapath_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic adc_valid,
   input wire logic adc_ready,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [15:0] out_i,
   input wire logic [15:0] out_q
);
   logic seen;
   logic [15:0] n_in;
   logic [15:0] n_out;
   // Tallies since reset: a word can never outrun the samples behind it
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         seen <= 1'b0;
         n_in <= 16'h0000;
         n_out <= 16'h0000;
      end
      else
      begin
         if (adc_valid && adc_ready && ce) seen <= 1'b1;
         n_in <= n_in + 16'(adc_valid && adc_ready && ce);
         n_out <= n_out + 16'(out_valid && out_ready && ce);
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_rel;
      $fell(rst);
   endsequence
   sequence s_stall;
      out_valid && !(out_ready && ce);
   endsequence
   reset_quiet_a: assert property (s_rel |-> !adc_ready && !out_valid && out_i == 16'h0000)
      else $error("outputs not cleared by reset");
   wake_quiet_a: assert property (s_rel |-> !out_valid [*4])
      else $error("word appeared too soon after reset");
   ready_wake_a: assert property (s_rel |-> ##[1:3] adc_ready)
      else $error("sample port did not open after reset");
   out_hold_a: assert property (s_stall |=> out_valid && $stable(out_i) && $stable(out_q))
      else $error("word changed or vanished while stalled");
   ce_freeze_a: assert property (!ce |=> $stable(adc_ready) && $stable(out_valid) && $stable(out_i))
      else $error("state moved with clock enable low");
   first_cause_a: assert property (out_valid |-> seen)
      else $error("word with no sample taken");
   min_latency_a: assert property ($rose(out_valid) |-> $past(seen, 3))
      else $error("word faster than the pipeline");
   drain_count_a: assert property (n_out <= n_in)
      else $error("more words than samples");
endmodule // iqd_datapath_chk

// File: verification/iqd_far_end.sv
/*
  Serializer model: drains words promptly, slowly or not at all.
  Assumes a word is taken on a rising clk edge with valid, ready and ce high.
*/
`timescale 1ns/1ps
module iqd_far_end (
   input wire logic clk,
   input wire logic [1:0] mode,
   input wire logic ce,
   input wire logic out_valid,
   output logic out_ready,
   input wire logic [15:0] out_i,
   input wire logic [15:0] out_q
);
   logic [15:0] gi [0:255];
   logic [15:0] gq [0:255];
   int n = 0;
   logic [1:0] ph = 2'h0;
   // Slow mode takes one cycle in four, so the FIFO backs up
   assign out_ready = mode == 2'h0 || (mode == 2'h1 && ph == 2'h0);
   // Record each taken word in arrival order
   always @(posedge clk)
   begin
      ph <= ph + 2'h1;
      if (out_valid && out_ready && ce)
      begin
         gi[n] <= out_i;
         gq[n] <= out_q;
         n <= n + 1;
      end
   end
endmodule // iqd_far_end

// File: verification/tb_iqd_datapath.sv
/*
  Bench for the demodulator datapath: serial writes, sample feeds, word checks.
  Assumes the far-end model records words; the checker is bound below.
*/
`timescale 1ns/1ps
module tb_iqd_datapath;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic sen_n = 1'b1;
   logic sclk = 1'b0;
   logic sdat = 1'b0;
   logic dsel = 1'b0;
   logic fire = 1'b0;
   logic av = 1'b0;
   logic [13:0] ad = 14'h0000;
   logic [1:0] mode = 2'h1;
   logic ar, ov, ordy, r;
   logic [15:0] oi, oq;
   logic [13:0] xs [3] = '{14'h1FFF, 14'h2000, 14'h0005};
   int err_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   int t, base;
   iqd_datapath iqd_datapath_i (.clk, .rst, .ce, .serial_enable_n(sen_n), .serial_clk(sclk),
      .serial_data(sdat), .digital_subchip_select(dsel), .transmit_fire_pulse(fire), .adc_data(ad),
      .adc_valid(av), .adc_ready(ar), .out_valid(ov), .out_ready(ordy), .out_i(oi), .out_q(oq));
   iqd_far_end iqd_far_end_i (.clk, .mode, .ce, .out_valid(ov), .out_ready(ordy), .out_i(oi), .out_q(oq));
   initial forever #12.5 clk = ~clk;
   // Hang guard: the run needs well under half this
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_count++;
         test_done();
      end
   end
   task test_done();
      if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task check(string nm, logic [15:0] seen, logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Serial frame: address then n data bits, each clock phase 4 cycles
   task wr(logic [7:0] a, logic [111:0] d, int n);
      logic [119:0] f;
      f = {a, d << (112 - n)};
      @(negedge clk);
      sen_n = 1'b0;
      for (int i = 0; i < 8 + n; i++)
      begin
         sdat = f[119 - i];
         repeat (4) @(negedge clk);
         sclk = 1'b1;
         repeat (4) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (8) @(negedge clk);
      sen_n = 1'b1;
      repeat (4) @(negedge clk);
   endtask
   // Valid held until k samples are taken; ready is read before its edge
   task feed(int k, logic [13:0] x);
      logic r0;
      @(negedge clk);
      av = 1'b1;
      ad = x;
      while (k > 0)
      begin
         r0 = ar;
         @(negedge clk);
         if (r0 === 1'b1) k--;
      end
      av = 1'b0;
   endtask
   task upto(int k);
      int w;
      w = 0;
      while (iqd_far_end_i.n <= k && w < 3000)
      begin
         @(negedge clk);
         w++;
      end
   endtask
   task want(int k, logic [15:0] ei, logic [15:0] eq);
      upto(k);
      check("out_i", iqd_far_end_i.gi[k], ei);
      check("out_q", iqd_far_end_i.gq[k], eq);
   endtask
   function automatic logic [111:0] blk(int bk);
      logic [111:0] v;
      v = 112'h0;
      for (int i = 0; i < 8; i++) v[14 * i +: 14] = 14'((i + 1) << (4 * bk));
      return v;
   endfunction
   // Impulse run: skip the flush, find the gap word, walk the symmetric taps
   task imp(int bk, int sh);
      int s, z, b;
      logic dn;
      s = iqd_far_end_i.n;
      feed(50, 14'h0000);
      upto(s + 49);
      z = s + 16;
      while (z < s + 32 && iqd_far_end_i.gi[z] !== 16'h0000) z++;
      dn = iqd_far_end_i.gi[z + 1] === 16'((8 << (4 * bk)) << sh);
      for (int k = 0; k < 16; k++)
      begin
         b = k < 8 ? k : 15 - k;
         if (dn) b = 7 - b;
         want(z + 1 + k, 16'(((b + 1) << (4 * bk)) << sh), 16'(((b + 1) << (4 * bk)) << sh));
      end
   endtask
   initial
   begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      // Memories go in first; second block and profile ride on auto-increment
      wr(8'hC6, 112'h0, 16);
      wr(8'hC7, blk(0), 112);
      wr(8'hC7, blk(1), 112);
      wr(8'hC8, 112'h0, 16);
      wr(8'hC9, 112'h0, 64);
      wr(8'hC9, 112'({8'h01, 6'h01, 16'h0000, 1'b0, 3'h6, 2'h0}), 64);
      wr(8'h4A, 112'h000D, 16);
      base = iqd_far_end_i.n;
      for (int k = 0; k < 3; k++)
      begin
         feed(1, xs[k]);
         want(base + k, {{2{xs[k][13]}}, xs[k]}, 16'h0000);
      end
      base += 3;
      // Stall the far end until the sample port refuses
      mode = 2'h2;
      @(negedge clk);
      av = 1'b1;
      ad = 14'h0000;
      t = 0;
      repeat (80)
      begin
         r = ar;
         @(negedge clk);
         if (r === 1'b1)
         begin
            t++;
            ad = ad + 14'h0001;
         end
      end
      av = 1'b0;
      check("adc_ready", {15'h0, ar}, 16'h0000);
      check("taken", 16'(t > 32), 16'h0000);
      mode = 2'h1;
      ce = 1'b0;
      repeat (3) @(negedge clk);
      ce = 1'b1;
      for (int k = 0; k < t; k++) want(base + k, 16'(k), 16'h0000);
      repeat (20) @(negedge clk);
      check("out_valid", {15'h0, ov}, 16'h0000);
      // Offset stage live; two writes that must not land
      wr(8'h4A, 112'h000C, 16);
      wr(8'h54, 112'h0010, 16);
      wr(8'h94, 112'h0020, 16);
      dsel = 1'b1;
      wr(8'h54, 112'h0030, 16);
      dsel = 1'b0;
      base = iqd_far_end_i.n;
      feed(1, 14'h0100);
      want(base, 16'h00F0, 16'h0000);
      // Mixer at a quarter turn per sample, phase restarted by a fire pulse;
      // one sample first moves the phase so that the restart is visible
      wr(8'h4A, 112'h0409, 16);
      wr(8'h60, 112'h0001, 16);
      wr(8'h61, 112'h4000, 16);
      base = iqd_far_end_i.n;
      feed(1, 14'h0100);
      want(base, 16'h0100, 16'h0000);
      fire = 1'b1;
      repeat (4) @(negedge clk);
      fire = 1'b0;
      repeat (6) @(negedge clk);
      feed(4, 14'h0100);
      want(base + 1, 16'h0100, 16'h0000);
      want(base + 2, 16'h0000, 16'hFF00);
      want(base + 3, 16'hFF00, 16'h0000);
      want(base + 4, 16'h0000, 16'h0100);
      // Impulses: profile 1 gives block 1 and G=6; then forced G=4 and block 0
      wr(8'h4A, 112'h2005, 16);
      wr(8'h4E, 112'h0800, 16);
      wr(8'h5D, 112'h0008, 16);
      imp(1, 2);
      wr(8'h5D, 112'h00C8, 16);
      wr(8'h5F, 112'h8041, 16);
      imp(0, 0);
      // Test wave, stages skipped: offset 3, amplitude 2^13, quarter turn a sample
      wr(8'h4A, 112'h000D, 16);
      wr(8'h5D, 112'h0004, 16);
      wr(8'h5E, 112'h07B0, 16);
      base = iqd_far_end_i.n;
      feed(4, 14'h0000);
      want(base, 16'h0003, 16'h0000);
      want(base + 1, 16'h1FFF, 16'h0000);
      want(base + 2, 16'h0003, 16'h0000);
      want(base + 3, 16'hE003, 16'h0000);
      test_done();
   end
endmodule // tb_iqd_datapath
bind iqd_datapath iqd_datapath_chk iqd_datapath_chk_i (.clk, .rst, .ce, .adc_valid, .adc_ready, .out_valid,
   .out_ready, .out_i, .out_q);
